// >>> ack_retransmit_message_framer.sv
`timescale 1ns/1ps
// What this block does
// - plain: start, payload, end; corrected: start, sequence, payload, CRC, end
// - hash character starts every sent frame and every host reply
// - sequence is one even hex character, zero through E
// - sequence changes only on valid acknowledge; message resent until then
// - payload limited to 72 characters
// - CRC field is four characters encoding the 16-bit CRC
// - CRC covers bytes after start up to the last one before CRC
// - every sent message ends with carriage return then line feed
// - acknowledge with wrong sequence does not advance; message is resent
// - at-sign means acknowledge, question mark means negative acknowledge
// - each corrected-mode send starts a response timer from the programmed delay
// - all-ones delay disables the response timer
// - timeout counts as negative acknowledge; both resend the same message
// - valid acknowledge: delivered, sequence advances, queue moves on
// - with parity on, the eighth bit enters the CRC
// - corrected mode holds three more messages queued behind the pending one
// - parity error on the start character: wait for end, then report an error
module ack_retransmit_message_framer
  import frame_pkg::*;
#(
  parameter logic [15:0] CRC_POLY = CRC_POLY_DEF,
  parameter logic [15:0] CRC_INIT = CRC_INIT_DEF,
  parameter int          UNIT_CYC = DELAY_UNIT_CYC
) (
  // clock and reset
  input  wire logic       I_CLK_SYS,
  input  wire logic       I_RST,
  // configuration
  input  wire logic       I_ERROR_CORRECTING_MODE,
  input  wire logic       I_PARITY_EN,
  input  wire logic       I_SET_RESPONSE_DELAY_CMD,
  input  wire logic [7:0] I_DELAY_VALUE,
  // message engine: one payload character per beat, last marks the end
  input  wire logic       I_MSG_VALID,
  output wire logic       O_MSG_READY,
  input  wire logic [7:0] I_MSG_CHAR,
  input  wire logic       I_MSG_LAST,
  // serial transmitter
  output wire logic       O_TX_VALID,
  input  wire logic       I_TX_READY,
  output wire logic [7:0] O_TX_CHAR,
  // serial receiver
  input  wire logic       I_RX_VALID,
  input  wire logic [7:0] I_RX_CHAR,
  input  wire logic       I_RX_PARITY_ERR,
  // status
  output logic            O_DELIVERED,
  output logic            O_RETRANSMIT,
  output logic            O_RX_ERROR,
  output logic [3:0]      O_SEQ
);
  localparam int MW = $clog2(PAYLOAD_MAX + 1);
  localparam int QW = $clog2(MSG_DEPTH);
  localparam int SW = QW + 7;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    return (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) return {1'b0, c[3:0]};
    if (c >= 8'h41 && c <= 8'h46) return {1'b0, c[3:0] + 4'h9};
    return 5'h10;
  endfunction

  // message store: one slot pending plus three queued
  logic [7:0]    store_reg [MSG_DEPTH][PAYLOAD_MAX];
  logic [MW-1:0] len_reg   [MSG_DEPTH];
  logic [QW-1:0] wr_slot_reg, rd_slot_reg;
  logic [QW:0]   used_reg;
  logic [MW-1:0] wr_idx_reg;
  wire           full = (used_reg == (QW+1)'(MSG_DEPTH));
  // plain mode keeps no queue: one slot only
  wire           q_full = I_ERROR_CORRECTING_MODE ? (used_reg == (QW+1)'(MSG_DEPTH)) : (used_reg != '0);
  wire           wr_fire = I_MSG_VALID && O_MSG_READY;
  wire           at_max  = (wr_idx_reg == MW'(PAYLOAD_MAX - 1));
  wire           wr_end  = wr_fire && (I_MSG_LAST || at_max);
  assign O_MSG_READY = !q_full;

  always_ff @(posedge I_CLK_SYS) begin
    if (wr_fire) begin
      store_reg[wr_slot_reg][wr_idx_reg] <= I_MSG_CHAR;
    end
  end

  // transmitter
  tx_state_t     tx_reg, tx_next;
  logic [MW-1:0] rd_idx_reg;
  logic [1:0]    nib_reg;
  logic [15:0]   crc_reg;
  logic [3:0]    seq_reg;
  logic [7:0]    delay_reg;
  logic [SW+7:0] timer_reg;
  logic          timer_on_reg;
  logic          ack_ok, nak_hit;
  logic [7:0]    tx_char;
  logic          tx_valid;
  wire           b_ready;
  wire           ecm = I_ERROR_CORRECTING_MODE;
  wire           tx_fire = tx_valid && b_ready;
  wire [7:0]     cur_char = store_reg[rd_slot_reg][rd_idx_reg];
  wire [MW-1:0]  cur_len = len_reg[rd_slot_reg];
  wire [3:0]     crc_nib = crc_reg[4'(4'd12 - {nib_reg, 2'b00}) +: 4];
  // parity lives in bit 7; without parity it is masked out of the CRC
  wire [7:0]     crc_in = I_PARITY_EN ? tx_char : {1'b0, tx_char[6:0]};
  wire           timeout = timer_on_reg && (timer_reg == '0);

  always_comb begin
    tx_next  = tx_reg;
    tx_valid = 1'b0;
    tx_char  = 8'h00;
    case (tx_reg)
      TX_IDLE: if (used_reg != '0) tx_next = TX_SOM;
      TX_SOM: begin
        tx_valid = 1'b1;
        tx_char  = CHAR_SOM;
        if (b_ready) tx_next = ecm ? TX_SEQ : TX_DATA;
      end
      TX_SEQ: begin
        tx_valid = 1'b1;
        tx_char  = hex_char(seq_reg);
        if (b_ready) tx_next = TX_DATA;
      end
      TX_DATA: begin
        tx_valid = (cur_len != '0);
        tx_char  = cur_char;
        if (cur_len == '0 || (b_ready && rd_idx_reg == cur_len - 1'b1)) tx_next = ecm ? TX_CRC : TX_CR;
      end
      TX_CRC: begin
        tx_valid = 1'b1;
        tx_char  = hex_char(crc_nib);
        if (b_ready && nib_reg == 2'd3) tx_next = TX_CR;
      end
      TX_CR: begin
        tx_valid = 1'b1;
        tx_char  = CHAR_CR;
        if (b_ready) tx_next = TX_LF;
      end
      TX_LF: begin
        tx_valid = 1'b1;
        tx_char  = CHAR_LF;
        if (b_ready) tx_next = ecm ? TX_WAIT : TX_NEXT;
      end
      TX_WAIT: begin
        if (ack_ok) tx_next = TX_NEXT;
        else if (nak_hit || timeout) tx_next = TX_SOM;
      end
      TX_NEXT: tx_next = TX_IDLE;
      default: tx_next = TX_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      tx_reg      <= TX_IDLE;
      rd_idx_reg  <= '0;
      nib_reg     <= 2'd0;
      crc_reg     <= CRC_INIT_DEF;
      seq_reg     <= SEQ_RESET;
      wr_slot_reg <= '0;
      rd_slot_reg <= '0;
      used_reg    <= '0;
      wr_idx_reg  <= '0;
      for (int k = 0; k < MSG_DEPTH; k++) len_reg[k] <= '0;
    end else begin
      tx_reg <= tx_next;
      if (wr_fire) wr_idx_reg <= wr_end ? '0 : wr_idx_reg + 1'b1;
      if (wr_end) begin
        len_reg[wr_slot_reg] <= wr_idx_reg + 1'b1;
        wr_slot_reg          <= wr_slot_reg + 1'b1;
      end
      if (tx_reg == TX_SOM) crc_reg <= CRC_INIT;
      else if (tx_fire && (tx_reg == TX_SEQ || tx_reg == TX_DATA)) crc_reg <= crc_step(crc_reg, crc_in);
      if (tx_reg == TX_SOM) rd_idx_reg <= '0;
      else if (tx_reg == TX_DATA && tx_fire) rd_idx_reg <= rd_idx_reg + 1'b1;
      if (tx_reg != TX_CRC) nib_reg <= 2'd0;
      else if (tx_fire) nib_reg <= nib_reg + 2'd1;
      if (tx_reg == TX_NEXT) rd_slot_reg <= rd_slot_reg + 1'b1;
      if (tx_reg == TX_WAIT && ack_ok) seq_reg <= seq_reg + SEQ_STEP;
      used_reg <= used_reg + {{QW{1'b0}}, wr_end} - {{QW{1'b0}}, tx_reg == TX_NEXT};
    end
  end

  // response timer, reloaded as each corrected-mode frame ends
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      delay_reg    <= DELAY_RESET;
      timer_reg    <= '0;
      timer_on_reg <= 1'b0;
    end else begin
      if (I_SET_RESPONSE_DELAY_CMD) delay_reg <= I_DELAY_VALUE;
      if (tx_reg == TX_LF && b_ready && ecm) begin
        timer_on_reg <= (delay_reg != DELAY_OFF);
        timer_reg    <= (SW+8)'(delay_reg * UNIT_CYC);
      end else if (tx_reg != TX_WAIT) begin
        timer_on_reg <= 1'b0;
      end else if (timer_reg != '0) begin
        timer_reg <= timer_reg - 1'b1;
      end
    end
  end

  // reply parser: # seq rsp crc4 CR
  rx_state_t   rx_reg;
  logic [3:0]  rseq_reg;
  logic        rack_reg, rbad_reg;
  logic [1:0]  rn_reg;
  logic [15:0] rcrc_reg, rgot_reg;
  wire  [7:0]  rx_c = I_PARITY_EN ? I_RX_CHAR : {1'b0, I_RX_CHAR[6:0]};
  wire  [4:0]  rx_h = hex_val(rx_c);
  wire         rx_som = I_RX_VALID && rx_c == CHAR_SOM;
  wire         rx_done = I_RX_VALID && rx_reg == RX_EOM && rx_c == CHAR_CR;
  wire         frame_ok = rx_done && !rbad_reg && (rgot_reg == rcrc_reg);
  assign ack_ok  = frame_ok && rack_reg && (rseq_reg == seq_reg);
  assign nak_hit = (frame_ok && (!rack_reg || rseq_reg != seq_reg)) || (rx_done && !frame_ok);

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      rx_reg     <= RX_HUNT;
      rseq_reg   <= 4'h0;
      rack_reg   <= 1'b0;
      rbad_reg   <= 1'b0;
      rn_reg     <= 2'd0;
      rcrc_reg   <= CRC_INIT_DEF;
      rgot_reg   <= 16'h0000;
      O_RX_ERROR <= 1'b0;
    end else begin
      O_RX_ERROR <= rx_done && rbad_reg;
      if (I_RX_VALID) begin
        if (I_RX_PARITY_ERR && I_PARITY_EN) rbad_reg <= 1'b1;
        case (rx_reg)
          RX_HUNT: if (rx_som) begin
            rx_reg   <= RX_SEQ;
            rbad_reg <= I_RX_PARITY_ERR && I_PARITY_EN;
            rcrc_reg <= CRC_INIT;
          end
          RX_SEQ: begin
            rseq_reg <= rx_h[3:0];
            rbad_reg <= rbad_reg || rx_h[4];
            rcrc_reg <= crc_step(rcrc_reg, rx_c);
            rx_reg   <= RX_RSP;
          end
          RX_RSP: begin
            rack_reg <= (rx_c == CHAR_ACK);
            rbad_reg <= rbad_reg || !(rx_c == CHAR_ACK || rx_c == CHAR_NAK);
            rcrc_reg <= crc_step(rcrc_reg, rx_c);
            rn_reg   <= 2'd0;
            rx_reg   <= RX_CRC;
          end
          RX_CRC: begin
            rgot_reg <= {rgot_reg[11:0], rx_h[3:0]};
            rbad_reg <= rbad_reg || rx_h[4];
            rn_reg   <= rn_reg + 2'd1;
            if (rn_reg == 2'd3) rx_reg <= RX_EOM;
          end
          RX_EOM: rx_reg <= RX_HUNT;
          default: rx_reg <= RX_HUNT;
        endcase
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      O_DELIVERED  <= 1'b0;
      O_RETRANSMIT <= 1'b0;
      O_SEQ        <= SEQ_RESET;
    end else begin
      O_DELIVERED  <= tx_reg == TX_WAIT && ack_ok;
      O_RETRANSMIT <= tx_reg == TX_WAIT && !ack_ok && (nak_hit || timeout);
      O_SEQ        <= seq_reg;
    end
  end

  // two-entry buffer toward the serial transmitter
  frame_buf2 #(.WIDTH(8)) i_frame_buf2 (
    .clk       (I_CLK_SYS),
    .rst       (I_RST),
    .in_valid  (tx_valid),
    .in_ready  (b_ready),
    .in_data   (tx_char),
    .out_valid (O_TX_VALID),
    .out_ready (I_TX_READY),
    .out_data  (O_TX_CHAR)
  );

  a_seq_even: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) seq_reg[0] == 1'b0)
    else $error("sequence value odd");
  a_seq_ack: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    (tx_reg == TX_WAIT && ack_ok) |=> seq_reg == $past(seq_reg) + SEQ_STEP)
    else $error("sequence did not step");
  a_seq_hold: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    !(tx_reg == TX_WAIT && ack_ok) |=> $stable(seq_reg))
    else $error("sequence changed without acknowledge");
  a_nak_resend: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    (tx_reg == TX_WAIT && !ack_ok && nak_hit) |=> tx_reg == TX_SOM && $stable(rd_slot_reg))
    else $error("no resend after negative reply");
  a_timeout_resend: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    (tx_reg == TX_WAIT && timeout && !ack_ok) |=> tx_reg == TX_SOM)
    else $error("no resend after timeout");
  a_off_no_timer: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    (delay_reg == DELAY_OFF && tx_reg == TX_LF) |=> !timer_on_reg)
    else $error("timer ran while disabled");
  a_som_first: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    (tx_next == TX_SOM && tx_reg != TX_SOM) |=> tx_valid && tx_char == CHAR_SOM)
    else $error("frame did not start with hash");
  a_cr_lf: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    (tx_reg == TX_CR && b_ready) |=> tx_reg == TX_LF && tx_char == CHAR_LF)
    else $error("carriage return not followed by line feed");
  a_len_limit: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    wr_idx_reg < MW'(PAYLOAD_MAX))
    else $error("payload above limit");
  a_ack_queue: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    (tx_reg == TX_WAIT && ack_ok) |=> ##1 rd_slot_reg == $past(rd_slot_reg, 2) + 1'b1)
    else $error("queue did not advance");
  a_plain_no_wait: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    (!ecm && tx_reg == TX_LF && b_ready) |=> tx_reg == TX_NEXT)
    else $error("plain frame waited for a reply");
  a_full_refused: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    full |-> !O_MSG_READY)
    else $error("message taken with queue full");
  // a reply with a parity error on its hash character is never taken as acknowledge
  a_bad_reply: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    (tx_reg == TX_WAIT && rx_done && rbad_reg) |=> O_RETRANSMIT && O_RX_ERROR)
    else $error("bad reply not reported");
  c_ack: cover property (@(posedge I_CLK_SYS) disable iff (I_RST) tx_reg == TX_WAIT && ack_ok);
  c_nak: cover property (@(posedge I_CLK_SYS) disable iff (I_RST) tx_reg == TX_WAIT && nak_hit);
  c_timeout: cover property (@(posedge I_CLK_SYS) disable iff (I_RST) tx_reg == TX_WAIT && timeout);
  c_queue_full: cover property (@(posedge I_CLK_SYS) disable iff (I_RST) full);
  c_rx_error: cover property (@(posedge I_CLK_SYS) disable iff (I_RST) O_RX_ERROR);
endmodule

// >>> frame_pkg.sv
package frame_pkg;
  localparam logic [7:0] CHAR_SOM  = 8'h23;
  localparam logic [7:0] CHAR_CR   = 8'h0d;
  localparam logic [7:0] CHAR_LF   = 8'h0a;
  localparam logic [7:0] CHAR_ACK  = 8'h40;
  localparam logic [7:0] CHAR_NAK  = 8'h3f;
  localparam int         PAYLOAD_MAX = 72;
  localparam int         MSG_DEPTH   = 4;
  localparam logic [3:0] SEQ_RESET   = 4'h0;
  localparam logic [3:0] SEQ_STEP    = 4'h2;
  localparam logic [7:0] DELAY_OFF   = 8'hff;
  localparam logic [7:0] DELAY_RESET = 8'h0a;
  // one delay unit in microseconds, and in cycles at 50 MHz
  localparam int         DELAY_UNIT_US   = 10;
  localparam int         CLK_MHZ         = 50;
  localparam int         DELAY_UNIT_CYC  = DELAY_UNIT_US * CLK_MHZ;
  localparam logic [15:0] CRC_POLY_DEF = 16'h1021;
  localparam logic [15:0] CRC_INIT_DEF = 16'h0000;
  typedef enum logic [8:0] {
    TX_IDLE = 9'h001,
    TX_SOM  = 9'h002,
    TX_SEQ  = 9'h004,
    TX_DATA = 9'h008,
    TX_CRC  = 9'h010,
    TX_CR   = 9'h020,
    TX_LF   = 9'h040,
    TX_WAIT = 9'h080,
    TX_NEXT = 9'h100
  } tx_state_t;
  typedef enum logic [4:0] {
    RX_HUNT = 5'h01,
    RX_SEQ  = 5'h02,
    RX_RSP  = 5'h04,
    RX_CRC  = 5'h08,
    RX_EOM  = 5'h10
  } rx_state_t;
endpackage

// >>> frame_buf2.sv
`timescale 1ns/1ps
module frame_buf2 #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output wire logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output wire logic             out_valid,
  input  wire logic             out_ready,
  output wire logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_reg [2];
  logic             wr_ptr_reg;
  logic             rd_ptr_reg;
  logic [1:0]       count_reg;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;
  assign in_ready  = (count_reg != 2'd2);
  assign out_valid = (count_reg != 2'd0);
  assign out_data  = mem_reg[rd_ptr_reg];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'd0;
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= in_data;
        wr_ptr_reg          <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end
  a_no_overflow: assert property (@(posedge clk) disable iff (rst) count_reg <= 2'd2)
    else $error("buffer count above two");
endmodule

// >>> host_model.sv
`timescale 1ns/1ps
module host_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // bench control
  input  wire logic       ecm,
  input  wire logic       par_en,
  input  wire logic       hold,
  input  wire logic       kick,
  input  wire logic [1:0] rmode,
  // device transmit side
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_char,
  // device receive side
  output logic            rx_valid,
  output logic [7:0]      rx_char,
  // last frame report
  output int              frames,
  output int              f_len,
  output logic [7:0]      f_first,
  output logic [7:0]      f_seq,
  output logic            f_ok
);
  logic [7:0]  fb [0:95];
  logic [7:0]  r [0:7];
  logic [7:0]  rc;
  logic [15:0] c;
  logic [1:0]  m;
  logic        in_frame;
  int          cnt;
  event        go;
  function automatic logic [7:0] hx(input logic [3:0] v);
    return (v > 4'h9) ? 8'h37 + v : 8'h30 + v;
  endfunction
  // bit 7 only counts with parity on
  function automatic logic [15:0] step(input logic [15:0] s, input logic [7:0] d);
    for (int i = 7; i >= 0; i--) s = {s[14:0], 1'b0} ^ ((s[15] ^ (d[i] & (i < 7 || par_en))) ? 16'h1021 : 16'h0);
    return s;
  endfunction
  function automatic logic [31:0] digits(input logic [15:0] v);
    return {hx(v[15:12]), hx(v[11:8]), hx(v[7:4]), hx(v[3:0])};
  endfunction
  assign tx_ready = ~hold & ~rst;
  // idle receive data shows the inverse of the last character, so a stale value never looks valid
  assign rx_char = rx_valid ? rc : ~rc;
  initial rx_valid = 1'b0;
  always @(posedge kick) -> go;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      frames   <= 0;
      cnt      <= 0;
      in_frame <= 1'b0;
    end else if (tx_valid && tx_ready) begin
      if (tx_char == 8'h23) begin
        in_frame <= 1'b1;
        cnt      <= 0;
      end else if (in_frame && tx_char == 8'h0a) begin
        c = 16'h0;
        for (int i = 0; i < cnt - 5; i++) c = step(c, fb[i]);
        f_ok     <= fb[cnt-1] == 8'h0d && (!ecm || {fb[cnt-5], fb[cnt-4], fb[cnt-3], fb[cnt-2]} == digits(c));
        f_len    <= ecm ? cnt - 6 : cnt - 1;
        f_first  <= ecm ? fb[1] : fb[0];
        f_seq    <= fb[0];
        in_frame <= 1'b0;
        frames   <= frames + 1;
        if (ecm) -> go;
      end else if (in_frame) begin
        fb[cnt] <= tx_char;
        cnt     <= cnt + 1;
      end
    end
  end
  // reply: hash, sequence (echoed, wrong in mode 2), response, crc, single CR
  always begin
    @(go);
    m = rmode;
    repeat (3) @(posedge clk);
    if (m != 2'd3 || kick) begin
      r[0] = 8'h23;
      r[1] = (m == 2'd2) ? ((f_seq == 8'h30) ? 8'h32 : 8'h30) : f_seq;
      r[2] = (m == 2'd1 || !f_ok) ? 8'h3f : 8'h40;
      {r[3], r[4], r[5], r[6]} = digits(step(step(16'h0, r[1]), r[2]));
      r[7] = 8'h0d;
      for (int i = 0; i < 8; i++) begin
        rx_valid <= 1'b1;
        rc       <= r[i];
        @(posedge clk);
      end
      rx_valid <= 1'b0;
    end
  end
endmodule

// >>> test_ack_retransmit_message_framer.sv
`timescale 1ns/1ps
module test_ack_retransmit_message_framer;
  import frame_pkg::*;
  logic       clk = 0, rst = 1, ecm = 0, par_en = 0, set_dly = 0, hold = 0, kick = 0, perr = 0;
  logic       msg_valid = 0, msg_last = 0;
  logic [7:0] dly = 8'h00, msg_char = 8'h00, f_first, f_seq;
  logic [1:0] rmode = 2'd0;
  logic [3:0] exp_seq = 4'h0;
  logic       f_ok;
  wire        tx_valid, tx_ready, msg_ready, rx_valid, delivered, retx, rx_err;
  wire  [7:0] tx_char, rx_char;
  wire  [3:0] seq;
  int         frames, f_len, err_total = 0, samples_checked = 0, n_del = 0, n_retx = 0, n_rxe = 0;
  ack_retransmit_message_framer #(.UNIT_CYC(4)) i_ack_retransmit_message_framer (
    .I_CLK_SYS(clk), .I_RST(rst), .I_ERROR_CORRECTING_MODE(ecm), .I_PARITY_EN(par_en),
    .I_SET_RESPONSE_DELAY_CMD(set_dly), .I_DELAY_VALUE(dly), .I_MSG_VALID(msg_valid),
    .O_MSG_READY(msg_ready), .I_MSG_CHAR(msg_char), .I_MSG_LAST(msg_last), .O_TX_VALID(tx_valid),
    .I_TX_READY(tx_ready), .O_TX_CHAR(tx_char), .I_RX_VALID(rx_valid), .I_RX_CHAR(rx_char),
    .I_RX_PARITY_ERR(perr), .O_DELIVERED(delivered), .O_RETRANSMIT(retx), .O_RX_ERROR(rx_err), .O_SEQ(seq));
  host_model i_host_model (
    .clk(clk), .rst(rst), .ecm(ecm), .par_en(par_en), .hold(hold), .kick(kick), .rmode(rmode),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_char(tx_char), .rx_valid(rx_valid), .rx_char(rx_char),
    .frames(frames), .f_len(f_len), .f_first(f_first), .f_seq(f_seq), .f_ok(f_ok));
  always #10 clk = ~clk;
  always @(posedge clk) begin
    if (delivered === 1'b1) n_del++;
    if (retx === 1'b1) n_retx++;
    if (rx_err === 1'b1) n_rxe++;
  end
  function automatic logic [7:0] hx(input logic [3:0] v);
    return (v > 4'h9) ? 8'h37 + v : 8'h30 + v;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_frames(input int n);
    int t;
    t = 0;
    while (frames < n && t < 3000) begin
      @(negedge clk);
      t++;
    end
    if (frames < n) begin
      chk(frames, n);
      stop_test;
    end
  endtask
  task automatic send_msg(input string s, input bit last);
    int t;
    @(posedge clk);
    for (int i = 0; i < s.len(); i++) begin
      msg_valid <= 1'b1;
      msg_char  <= s[i];
      msg_last  <= last && (i == s.len() - 1);
      t = 0;
      do begin
        @(negedge clk);
        t++;
      end while (msg_ready !== 1'b1 && t < 2000);
      if (msg_ready !== 1'b1) begin
        chk(msg_ready, 1'b1);
        stop_test;
      end
      @(posedge clk);
    end
    msg_valid <= 1'b0;
    msg_last  <= 1'b0;
  endtask
  task automatic set_delay(input logic [7:0] v);
    @(posedge clk);
    dly     <= v;
    set_dly <= 1'b1;
    @(posedge clk);
    set_dly <= 1'b0;
  endtask
  // receiver stalls long enough to fill the transmit buffer
  task automatic t_plain;
    int f0;
    f0 = frames;
    @(posedge clk);
    hold <= 1'b1;
    fork
      send_msg("AB", 1'b1);
      begin
        repeat (20) @(posedge clk);
        hold <= 1'b0;
      end
    join
    wait_frames(f0 + 1);
    chk(f_len, 2);
    chk(f_first, 8'h41);
    chk(f_ok, 1'b1);
    $display("plain frame test done");
  endtask
  task automatic t_ack(input string s);
    int f0, d0;
    f0 = frames;
    d0 = n_del;
    rmode <= 2'd0;
    send_msg(s, 1'b1);
    wait_frames(f0 + 1);
    repeat (20) @(posedge clk);
    chk(f_seq, hx(exp_seq));
    chk(f_len, s.len());
    chk(f_ok, 1'b1);
    chk(n_del, d0 + 1);
    exp_seq = exp_seq + 4'h2;
    chk(seq, exp_seq);
    $display("acknowledged frame test done");
  endtask
  // parity errors in a reply: refused, reported, and the frame comes back
  task automatic t_perr;
    int f0, d0, r0, e0;
    f0 = frames;
    d0 = n_del;
    r0 = n_retx;
    e0 = n_rxe;
    rmode <= 2'd0;
    perr  <= 1'b1;
    send_msg("PE", 1'b1);
    wait_frames(f0 + 1);
    // keep the error up until the whole first reply has been taken
    repeat (14) @(posedge clk);
    perr <= 1'b0;
    wait_frames(f0 + 2);
    repeat (20) @(posedge clk);
    chk(n_rxe, e0 + 1);
    chk(n_retx, r0 + 1);
    chk(n_del, d0 + 1);
    exp_seq = exp_seq + 4'h2;
    chk(seq, exp_seq);
    $display("parity error test done");
  endtask
  // a refused or missing first reply must bring back the same frame
  task automatic t_resend(input logic [1:0] mode);
    int f0, d0, r0;
    f0 = frames;
    d0 = n_del;
    r0 = n_retx;
    rmode <= mode;
    send_msg("RS", 1'b1);
    wait_frames(f0 + 1);
    rmode <= 2'd0;
    wait_frames(f0 + 2);
    chk(seq, exp_seq);
    chk(f_seq, hx(exp_seq));
    chk(f_first, 8'h52);
    repeat (20) @(posedge clk);
    chk(n_retx, r0 + 1);
    chk(n_del, d0 + 1);
    exp_seq = exp_seq + 4'h2;
    chk(seq, exp_seq);
    $display("resend test done for mode %0d", mode);
  endtask
  // timer off: pending frame waits, three more queue up behind it
  task automatic t_off;
    int f0, d0, r0;
    f0 = frames;
    d0 = n_del;
    r0 = n_retx;
    set_delay(8'hff);
    rmode <= 2'd3;
    send_msg("Q0", 1'b1);
    wait_frames(f0 + 1);
    send_msg("Q1", 1'b1);
    send_msg("Q2", 1'b1);
    send_msg("Q3", 1'b1);
    repeat (300) @(posedge clk);
    chk(n_retx, r0);
    chk(frames, f0 + 1);
    chk(msg_ready, 1'b0);
    rmode <= 2'd0;
    kick  <= 1'b1;
    @(posedge clk);
    kick <= 1'b0;
    wait_frames(f0 + 4);
    repeat (20) @(posedge clk);
    chk(n_del, d0 + 4);
    exp_seq = exp_seq + 4'h8;
    chk(seq, exp_seq);
    $display("queue and timer off test done");
  endtask
  task automatic t_limit;
    string s;
    int    f0;
    s  = "";
    f0 = frames;
    for (int i = 0; i < 72; i++) s = {s, "x"};
    send_msg(s, 1'b0);
    send_msg("y", 1'b1);
    wait_frames(f0 + 1);
    chk(f_len, 72);
    wait_frames(f0 + 2);
    chk(f_len, 1);
    $display("payload limit test done");
  endtask
  initial begin
    string p;
    repeat (3) @(posedge clk);
    chk(seq, 4'h0);
    chk(msg_ready, 1'b1);
    chk(tx_valid, 1'b0);
    chk(rx_err, 1'b0);
    rst <= 1'b0;
    t_plain;
    @(posedge clk);
    ecm    <= 1'b1;
    par_en <= 1'b1;
    p = "K9";
    p[1] = 8'hc1;
    t_ack(p);
    t_perr;
    par_en <= 1'b0;
    t_resend(2'd1);
    t_resend(2'd2);
    set_delay(8'h08);
    t_resend(2'd3);
    t_off;
    @(posedge clk);
    ecm <= 1'b0;
    t_limit;
    stop_test;
  end
endmodule
